// ---- shared/codec_flag_pkg.sv ----
// Register map, field masks and reset values of the codec status flag bank.
// Assumes byte addresses on the register bus equal four times the index.
package codec_flag_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // **********************************************************
    // Register indices
    // **********************************************************
    localparam logic [5:0] GAIN_IDX = 6'h26;
    localparam logic [5:0] OVF_IDX = 6'h27;
    localparam logic [5:0] RSV_IDX0 = 6'h28;
    localparam logic [5:0] PLAY_IDX = 6'h2C;
    localparam logic [5:0] REC_IDX = 6'h2D;
    localparam int RSV_COUNT = 4;

    function automatic logic [ADDR_W-1:0] idx_to_addr(
        input logic [5:0] idx
    );
        return {idx, 2'b00};
    endfunction

    localparam logic [ADDR_W-1:0] RSV_BASE_ADDR = idx_to_addr(RSV_IDX0);

    // **********************************************************
    // Field positions and masks
    // **********************************************************
    localparam int GAIN_LEFT_BIT = 4;
    localparam int GAIN_RIGHT_BIT = 0;
    localparam int REC_DC_BIT = 2;
    localparam logic [7:0] GAIN_RSV_MASK = 8'hEE;
    localparam logic [7:0] OVF_STICKY_MASK = 8'hEA;
    localparam logic [7:0] OVF_RSV_MASK = 8'h15;
    localparam logic [7:0] PLAY_STICKY_MASK = 8'hFF;
    localparam logic [7:0] REC_STICKY_MASK = 8'h58;
    localparam logic [7:0] REC_RSV_MASK = 8'hA3;

    // **********************************************************
    // Reset values and bus answers
    // **********************************************************
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] RSV_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hdl/flag_sticky_bank.sv ----
// A byte of sticky flags: level sources set them, a clear pulse drops them.
// Assumes sources and clear run on aclk; a set in the clear cycle wins.
`timescale 1ns/1ps
module flag_sticky_bank
    import codec_flag_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] KEEP_MASK = '1
)
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, low
    input wire logic [WIDTH-1:0] set_in, // Source levels
    input wire logic clear_in, // Read-clear pulse
    output logic [WIDTH-1:0] flags_out // Flag state
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // Set beats clear so an event on the read edge survives
    assign flags_next = ((flags_reg & ~{WIDTH{clear_in}}) | set_in)
        & KEEP_MASK;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end

    assign flags_out = flags_reg;

endmodule

// ---- hdl/codec_status_flags.sv ----
// Codec status and sticky event flag bank behind an AXI4-Lite slave.
// Assumes all flag sources are levels from logic on aclk.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module codec_status_flags
    import codec_flag_pkg::*;
(
    input wire logic aclk, // Clock, 100 MHz
    input wire logic aresetn, // Sync reset, low
    input wire logic [ADDR_W-1:0] awaddr, // Write address
    input wire logic [2:0] awprot, // Unused protection
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic [STRB_W-1:0] wstrb, // Byte enables
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [ADDR_W-1:0] araddr, // Read address
    input wire logic [2:0] arprot, // Unused protection
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [DATA_W-1:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic gain_left_match, // Left gain stage settled
    input wire logic gain_right_match, // Right gain stage settled
    input wire logic ovf_play_left, // Left playback overflow
    input wire logic ovf_play_right, // Right playback overflow
    input wire logic ovf_play_shift, // Playback shifter overflow
    input wire logic ovf_rec_conv, // Record converter overflow
    input wire logic ovf_rec_shift, // Record shifter overflow
    input wire logic short_left, // Left driver short
    input wire logic short_right, // Right driver short
    input wire logic button_press, // Headset button pressed
    input wire logic headset_change, // Insertion or removal
    input wire logic compress_left_above, // Left power over threshold
    input wire logic compress_right_above, // Right power over threshold
    input wire logic play_engine_std, // Playback engine std port
    input wire logic play_engine_aux, // Playback engine aux port
    input wire logic gain_ctrl_noise_below, // Record power under noise
    input wire logic rec_engine_std, // Record engine std port
    input wire logic rec_engine_aux, // Record engine aux port
    input wire logic dc_meas_avail // DC measurement available
);

    // **********************************************************
    // Address decode helpers
    // **********************************************************
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [5:0] idx
    );
        return addr == idx_to_addr(idx);
    endfunction

    function automatic logic rsv_hit(input logic [ADDR_W-1:0] addr);
        return (addr[7:4] == RSV_BASE_ADDR[7:4]) && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic known_hit(input logic [ADDR_W-1:0] addr);
        return reg_hit(addr, GAIN_IDX) || reg_hit(addr, OVF_IDX)
            || reg_hit(addr, PLAY_IDX) || reg_hit(addr, REC_IDX)
            || rsv_hit(addr);
    endfunction

    // **********************************************************
    // Write channel state
    // **********************************************************
    logic aw_full_reg;
    logic w_full_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [7:0] wr_byte_reg;
    logic wr_lane_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic aw_hs;
    logic w_hs;
    logic wr_commit;
    logic wr_en_byte;
    logic wr_gain;
    logic wr_ovf;
    logic wr_rec;
    logic wr_rsv;

    assign awready = !aw_full_reg;
    assign wready = !w_full_reg;
    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign wr_commit = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_en_byte = wr_commit && wr_lane_reg;
    assign wr_gain = wr_en_byte && reg_hit(wr_addr_reg, GAIN_IDX);
    assign wr_ovf = wr_en_byte && reg_hit(wr_addr_reg, OVF_IDX);
    assign wr_rec = wr_en_byte && reg_hit(wr_addr_reg, REC_IDX);
    assign wr_rsv = wr_en_byte && rsv_hit(wr_addr_reg);
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // Address and data may land in either order; commit once both held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_byte_reg <= 8'h00;
            wr_lane_reg <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_full_reg <= 1'b1;
                wr_addr_reg <= awaddr;
            end
            else if (wr_commit)
                aw_full_reg <= 1'b0;
            if (w_hs)
            begin
                w_full_reg <= 1'b1;
                wr_byte_reg <= wdata[7:0];
                wr_lane_reg <= wstrb[0];
            end
            else if (wr_commit)
                w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (wr_commit)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= known_hit(wr_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_reg && bready)
            bvalid_reg <= 1'b0;
    end

    // **********************************************************
    // Reserved bit storage
    // **********************************************************
    // Stored as written; software is expected to keep the safe values
    logic [7:0] gain_rsv_reg;
    logic [7:0] ovf_rsv_reg;
    logic [7:0] rec_rsv_reg;
    logic [7:0] rsv_bank_reg [RSV_COUNT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gain_rsv_reg <= RSV_RESET;
            ovf_rsv_reg <= RSV_RESET;
            rec_rsv_reg <= RSV_RESET;
        end
        else
        begin
            if (wr_gain)
                gain_rsv_reg <= wr_byte_reg & GAIN_RSV_MASK;
            if (wr_ovf)
                ovf_rsv_reg <= wr_byte_reg & OVF_RSV_MASK;
            if (wr_rec)
                rec_rsv_reg <= wr_byte_reg & REC_RSV_MASK;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < RSV_COUNT; i++)
                rsv_bank_reg[i] <= RSV_RESET;
        end
        else if (wr_rsv)
            rsv_bank_reg[wr_addr_reg[3:2]] <= wr_byte_reg;
    end

    // **********************************************************
    // Sticky flag banks
    // **********************************************************
    logic ar_hs;
    logic rd_clr_ovf;
    logic rd_clr_play;
    logic rd_clr_rec;
    logic [7:0] ovf_src;
    logic [7:0] play_src;
    logic [7:0] rec_src;
    logic [7:0] ovf_flags;
    logic [7:0] play_flags;
    logic [7:0] rec_flags;

    assign ar_hs = arvalid && arready;
    // The clear lands on the same edge that captures the read data
    assign rd_clr_ovf = ar_hs && reg_hit(araddr, OVF_IDX);
    assign rd_clr_play = ar_hs && reg_hit(araddr, PLAY_IDX);
    assign rd_clr_rec = ar_hs && reg_hit(araddr, REC_IDX);

    assign ovf_src = {ovf_play_left, ovf_play_right,
        ovf_play_shift, 1'b0,
        ovf_rec_conv, 1'b0,
        ovf_rec_shift, 1'b0};
    assign play_src = {short_left, short_right,
        button_press, headset_change,
        compress_left_above, compress_right_above,
        play_engine_std, play_engine_aux};
    assign rec_src = {1'b0, gain_ctrl_noise_below, 1'b0,
        rec_engine_std, rec_engine_aux, 3'b000};

    flag_sticky_bank #(.WIDTH(8), .KEEP_MASK(OVF_STICKY_MASK)) ovf_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(ovf_src),
        .clear_in(rd_clr_ovf),
        .flags_out(ovf_flags)
    );

    flag_sticky_bank #(.WIDTH(8), .KEEP_MASK(PLAY_STICKY_MASK)) play_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(play_src),
        .clear_in(rd_clr_play),
        .flags_out(play_flags)
    );

    flag_sticky_bank #(.WIDTH(8), .KEEP_MASK(REC_STICKY_MASK)) rec_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(rec_src),
        .clear_in(rd_clr_rec),
        .flags_out(rec_flags)
    );

    // **********************************************************
    // Read channel
    // **********************************************************
    logic [7:0] gain_view;
    logic [7:0] ovf_view;
    logic [7:0] rec_view;
    logic [7:0] rd_byte;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [DATA_W-1:0] rdata_reg;

    assign gain_view = gain_rsv_reg
        | (8'(gain_left_match) << GAIN_LEFT_BIT)
        | (8'(gain_right_match) << GAIN_RIGHT_BIT);
    assign ovf_view = ovf_flags | ovf_rsv_reg;
    assign rec_view = rec_flags | rec_rsv_reg
        | (8'(dc_meas_avail) << REC_DC_BIT);
    assign rd_byte = reg_hit(araddr, GAIN_IDX) ? gain_view
        : reg_hit(araddr, OVF_IDX) ? ovf_view
        : reg_hit(araddr, PLAY_IDX) ? play_flags
        : reg_hit(araddr, REC_IDX) ? rec_view
        : rsv_hit(araddr) ? rsv_bank_reg[araddr[3:2]]
        : 8'h00;

    assign arready = !rvalid_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
        end
        else if (ar_hs)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= known_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= {{(DATA_W-8){1'b0}}, rd_byte};
        end
        else if (rvalid_reg && rready)
            rvalid_reg <= 1'b0;
    end

    // **********************************************************
    // Assertions
    // **********************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sticky_hold_a: assert property (
        ovf_flags[7] && !rd_clr_ovf |=> ovf_flags[7])
        else $error("overflow flag dropped without a read");

    read_clear_a: assert property (
        rd_clr_play && !short_left |=> !play_flags[7])
        else $error("short flag not cleared by read");

    read_returns_a: assert property (
        rd_clr_play |=> rvalid && rdata[7:0] == $past(play_flags))
        else $error("read data not the pre-clear flags");

    set_wins_a: assert property (
        rd_clr_ovf && ovf_play_right |=> ovf_flags[6])
        else $error("event lost in read-clear cycle");

    gain_left_a: assert property (
        ar_hs && reg_hit(araddr, GAIN_IDX)
        |=> rdata[GAIN_LEFT_BIT] == $past(gain_left_match))
        else $error("left gain status wrong");

    gain_right_a: assert property (
        ar_hs && reg_hit(araddr, GAIN_IDX)
        |=> rdata[GAIN_RIGHT_BIT] == $past(gain_right_match))
        else $error("right gain status wrong");

    ovf_left_a: assert property (
        ovf_play_left |=> ovf_flags[7])
        else $error("left overflow not flagged");

    ovf_shift_a: assert property (
        ovf_play_shift |=> ovf_flags[5])
        else $error("playback shifter overflow not flagged");

    rec_ovf_a: assert property (
        ovf_rec_conv ##1 !rd_clr_ovf |=> ovf_flags[3])
        else $error("record converter overflow lost");

    rec_shift_a: assert property (
        ovf_rec_shift |=> ovf_flags[1])
        else $error("record shifter overflow not flagged");

    short_right_a: assert property (
        short_right |=> play_flags[6])
        else $error("right short not flagged");

    headset_a: assert property (
        button_press && headset_change |=> play_flags[5:4] == 2'b11)
        else $error("headset events not flagged");

    compress_power_a: assert property (
        compress_left_above || compress_right_above
        |=> |play_flags[3:2])
        else $error("compression power flag missing");

    engine_flags_a: assert property (
        play_engine_aux && rec_engine_std
        |=> play_flags[0] && rec_flags[4])
        else $error("engine port flag missing");

    noise_flag_a: assert property (
        gain_ctrl_noise_below |=> rec_flags[6])
        else $error("noise flag missing");

    dc_status_a: assert property (
        ar_hs && reg_hit(araddr, REC_IDX)
        |=> rdata[REC_DC_BIT] == $past(dc_meas_avail))
        else $error("DC availability bit wrong");

    ro_write_a: assert property (
        wr_commit && reg_hit(wr_addr_reg, PLAY_IDX) && play_src == 8'h00
        && !rd_clr_play |=> play_flags == $past(play_flags))
        else $error("write changed read-only flags");

    rsv_store_a: assert property (
        wr_ovf |=> ovf_rsv_reg == ($past(wr_byte_reg) & OVF_RSV_MASK))
        else $error("reserved bits not stored");

    resp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    rdata_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed while waiting");

    write_resp_a: assert property (
        wr_commit |=> bvalid ##0 !aw_full_reg)
        else $error("write response not one cycle after commit");

    cov_read_clear_c: cover property (
        play_flags[7] ##1 rd_clr_play ##1 !play_flags[7]);
    cov_set_wins_c: cover property (rd_clr_ovf && ovf_play_right);
    cov_data_first_c: cover property (w_hs && !aw_full_reg ##1 aw_hs);
    cov_slverr_c: cover property (rvalid && rresp == RESP_SLVERR);

endmodule

// ---- bench/codec_status_flag_bank_tb_top.sv ----
// Self-checking bench for the codec status flag bank over AXI4-Lite.
// Assumes the flag package is compiled first; the bench drives all ports.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    fail_count++; $display("Error at %0t: got %h expected %h", \
    $time, g, e); end end
module codec_status_flag_bank_tb_top;
    import codec_flag_pkg::*;
    localparam int LIMIT = 10000;
    logic aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] ovf_src, play_src, rec_src;
    logic gl, gr, dc;
    logic [7:0] ovf_stk, play_stk, rec_stk;
    logic [5:0] flag_idx [4] = '{GAIN_IDX, OVF_IDX, PLAY_IDX, REC_IDX};
    logic [7:0] rsv_mask [4] = '{GAIN_RSV_MASK, OVF_RSV_MASK, 8'h00,
        REC_RSV_MASK};
    int fail_count, tests_run, cycles;

    codec_status_flags u_codec_status_flags (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .gain_left_match(gl), .gain_right_match(gr),
        .ovf_play_left(ovf_src[7]), .ovf_play_right(ovf_src[6]),
        .ovf_play_shift(ovf_src[5]), .ovf_rec_conv(ovf_src[3]),
        .ovf_rec_shift(ovf_src[1]), .short_left(play_src[7]),
        .short_right(play_src[6]), .button_press(play_src[5]),
        .headset_change(play_src[4]), .compress_left_above(play_src[3]),
        .compress_right_above(play_src[2]), .play_engine_std(play_src[1]),
        .play_engine_aux(play_src[0]), .gain_ctrl_noise_below(rec_src[6]),
        .rec_engine_std(rec_src[4]), .rec_engine_aux(rec_src[3]),
        .dc_meas_avail(dc)
    );

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ********************
    // Expectation and bus tasks
    // ********************
    function automatic logic [7:0] expv(input logic [5:0] idx);
        case (idx)
            GAIN_IDX: return {3'h0, gl, 3'h0, gr};
            OVF_IDX: return ovf_stk;
            PLAY_IDX: return play_stk;
            REC_IDX: return rec_stk | {5'h0, dc, 2'h0};
            default: return 8'h00;
        endcase
    endfunction

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic axi_write(input logic [7:0] a, d, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= 32'(d);
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        `CHK(bresp, er)
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Read clears the model too, except where a source is still held
    task automatic check_reg(input logic [5:0] idx);
        logic [7:0] e;
        logic [31:0] d;
        logic [1:0] r;
        e = expv(idx);
        axi_read({idx, 2'b00}, d, r);
        `CHK(d, 32'(e))
        `CHK(r, RESP_OKAY)
        case (idx)
            OVF_IDX: ovf_stk = ovf_src;
            PLAY_IDX: play_stk = play_src;
            REC_IDX: rec_stk = rec_src;
            default: ;
        endcase
    endtask

    task automatic apply(input logic [7:0] o, p, r, input logic [2:0] lv);
        @(posedge aclk);
        ovf_src <= o & OVF_STICKY_MASK;
        play_src <= p;
        rec_src <= r & REC_STICKY_MASK;
        {gl, gr, dc} <= lv;
        @(posedge aclk);
        {ovf_src, play_src, rec_src} <= '0;
        ovf_stk |= o & OVF_STICKY_MASK;
        play_stk |= p;
        rec_stk |= r & REC_STICKY_MASK;
    endtask

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        {awaddr, araddr, awvalid, wvalid, arvalid, bready, rready} = '0;
        {wdata, wstrb, ovf_src, play_src, rec_src, gl, gr, dc} = '0;
        {ovf_stk, play_stk, rec_stk} = '0;
        aresetn = 1'b0;
        void'($urandom(32'h52CC));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            check_reg(GAIN_IDX + 6'(i));
        axi_read(8'hB8, d, r);
        `CHK(d, 32'h0)
        `CHK(r, RESP_SLVERR)
        axi_write(8'h00, 8'h00, 4'h1, RESP_SLVERR);
        // Each bit position alone, then a second read where the sticky flags must come back clear
        for (int b = 0; b < 8; b++)
        begin
            apply(8'h01 << b, 8'h01 << b, 8'h01 << b, 3'(b));
            for (int k = 0; k < 2; k++)
                foreach (flag_idx[j])
                    check_reg(flag_idx[j]);
        end
        // Writes keep reserved bits at zero and must leave flags alone
        apply(8'hFF, 8'hFF, 8'hFF, 3'h7);
        foreach (flag_idx[j])
        begin
            axi_write({flag_idx[j], 2'b00}, 8'($urandom) & ~rsv_mask[j],
                (j == 0) ? 4'hE : 4'($urandom), RESP_OKAY);
            check_reg(flag_idx[j]);
        end
        for (int i = 0; i < RSV_COUNT; i++)
        begin
            axi_write(RSV_BASE_ADDR + 8'(4 * i), RSV_RESET, 4'h1,
                RESP_OKAY);
            check_reg(RSV_IDX0 + 6'(i));
        end
        // Source held across reads: the set must win over the clear
        @(posedge aclk);
        play_src <= 8'h80;
        ovf_src <= 8'h40;
        play_stk |= 8'h80;
        ovf_stk |= 8'h40;
        check_reg(PLAY_IDX);
        check_reg(OVF_IDX);
        check_reg(PLAY_IDX);
        @(posedge aclk);
        play_src <= 8'h00;
        ovf_src <= 8'h00;
        check_reg(OVF_IDX);
        check_reg(OVF_IDX);
        check_reg(PLAY_IDX);
        check_reg(PLAY_IDX);
        for (int i = 0; i < 40; i++)
        begin
            apply(8'($urandom), 8'($urandom), 8'($urandom), 3'($urandom));
            if (i % 2 == 1)
                apply(8'($urandom), 8'($urandom), 8'($urandom),
                    3'($urandom));
            foreach (flag_idx[j])
                check_reg(flag_idx[j]);
            check_reg(flag_idx[$urandom % 4]);
        end
        check_reg(REC_IDX);
        close_out();
    end
endmodule
